// ===== esd_addr_resolve.sv
`timescale 1ns/10ps
// ***********************************************
// file operand to data address
// ***********************************************
module esd_addr_resolve (
  input wire logic ext,
  input wire logic acc,
  input wire logic [7:0] f,
  input wire logic [3:0] bank,
  input wire logic [esd_pkg::AW-1:0] sp,
  output logic [esd_pkg::AW-1:0] addr
);
  always_comb begin
    if (ext && !acc && f <= esd_pkg::OFFSET_LIMIT) begin
      addr = sp + {4'h0, f};
    end else if (acc) begin
      addr = {bank, f};
    end else if (f > esd_pkg::OFFSET_LIMIT) begin
      addr = {esd_pkg::ACC_HI_BANK, f};
    end else begin
      addr = {4'h0, f};
    end
  end
endmodule

// ===== esd_decode.sv
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Function
// - move indexed to indexed: both addresses are pointer plus 7-bit offsets; flags kept
// - two words: first 1110 1011 1 plus source, second 1111 plus destination
// - source landing on an indirect register reads as zero
// - destination landing on an indirect register writes nothing
// - source and destination reach the whole 4096-byte space
// - push literal stores byte at stack pointer, then decrements pointer
// - push literal opcode upper byte 1111 1010, literal in low byte
// - subtract 6-bit literal from pointer chosen by selector 0 to 2
// - subtract from pointer: one word, one cycle, 1110 1001 ffkk kkkk
// - selector 3 means subtract and return on stack pointer
// - subtract and return reloads program counter, second cycle idle
// - extension enable also turns on indexed literal offset addressing
// - enabled, access bit clear, operand up to 5Fh is pointer offset
// - disabled: operand literal, access bank or bank select register bank
// - destination bit keeps its meaning in indexed mode
// - extension enable bit resets to 0 and gates all of the above
module esd_decode (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ins_valid,
  input wire logic [15:0] ins_word,
  output logic ins_ready,
  output logic ins_done,
  input wire logic [esd_pkg::PCW-1:0] return_stack_top,
  output logic pc_load,
  output logic [esd_pkg::PCW-1:0] pc_value,
  output logic mem_re,
  output logic mem_we,
  output logic [esd_pkg::AW-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic std_valid,
  input wire logic [7:0] std_f,
  input wire logic std_a,
  input wire logic std_d,
  input wire logic [3:0] bank_select_register,
  output logic res_valid,
  output logic [esd_pkg::AW-1:0] res_addr,
  output logic res_d
);
  esd_pkg::esd_regs_t r_reg;
  esd_pkg::esd_regs_t r_next;
  logic [esd_pkg::AW-1:0] sp;
  logic [esd_pkg::AW-1:0] idx_sum;
  logic [esd_pkg::AW-1:0] push_dec;
  logic [esd_pkg::AW-1:0] sub_res;
  logic [esd_pkg::AW-1:0] std_addr;
  logic [7:0] idx_off;
  logic [1:0] sub_sel;
  logic take;

  assign sp = r_reg.ptr[esd_pkg::SEL_STACK_PTR];
  assign take = ins_valid && r_reg.ins_ready;
  assign sub_sel = (ins_word[7:6] == esd_pkg::SEL_RETURN) ? esd_pkg::SEL_STACK_PTR
                                                           : ins_word[7:6];
  assign idx_off = (r_reg.st == esd_pkg::ESD_MV_WORD2) ? {1'b0, ins_word[6:0]}
                                                      : {1'b0, r_reg.zs};

  // ***********************************************
  // address arithmetic
  // ***********************************************
  esd_ptr_alu u_idx (
    .base(sp),
    .off(idx_off),
    .sub(1'b0),
    .result(idx_sum)
  );
  esd_ptr_alu u_push (
    .base(sp),
    .off(esd_pkg::PUSH_STEP),
    .sub(1'b1),
    .result(push_dec)
  );
  esd_ptr_alu u_sub (
    .base(r_reg.ptr[sub_sel]),
    .off({2'h0, ins_word[5:0]}),
    .sub(1'b1),
    .result(sub_res)
  );
  esd_addr_resolve u_res (
    .ext(r_reg.ext),
    .acc(std_a),
    .f(std_f),
    .bank(bank_select_register),
    .sp(sp),
    .addr(std_addr)
  );

  always_comb begin
    r_next = r_reg;
    r_next.mem.re = 1'b0;
    r_next.mem.we = 1'b0;
    r_next.pc_load = 1'b0;
    r_next.done = 1'b0;

    // ***********************************************
    // register bus
    // ***********************************************
    if (s_axi_awvalid && r_reg.axi.awready) begin
      r_next.axi.aw_got = 1'b1;
      r_next.axi.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.axi.wready) begin
      r_next.axi.w_got = 1'b1;
      r_next.axi.wdata = s_axi_wdata;
      r_next.axi.wstrb = s_axi_wstrb;
    end
    if (r_reg.axi.aw_got && r_reg.axi.w_got) begin
      r_next.axi.aw_got = 1'b0;
      r_next.axi.w_got = 1'b0;
      r_next.axi.bvalid = 1'b1;
      r_next.axi.bresp = esd_pkg::RESP_OKAY;
      case (r_reg.axi.aw_addr)
        esd_pkg::REG_CTRL: begin
          if (r_reg.axi.wstrb[0]) begin
            r_next.ext = r_reg.axi.wdata[0];
          end
        end
        esd_pkg::REG_STATUS: begin
          r_next.axi.bresp = esd_pkg::RESP_OKAY;
        end
        esd_pkg::REG_PTR0, esd_pkg::REG_PTR1, esd_pkg::REG_PTR2: begin
          for (int i = 0; i < 3; i++) begin
            if (r_reg.axi.aw_addr == esd_pkg::REG_PTR0 + 8'(4 * i)) begin
              if (r_reg.axi.wstrb[0]) begin
                r_next.ptr[i][7:0] = r_reg.axi.wdata[7:0];
              end
              if (r_reg.axi.wstrb[1]) begin
                r_next.ptr[i][11:8] = r_reg.axi.wdata[11:8];
              end
            end
          end
        end
        default: begin
          r_next.axi.bresp = esd_pkg::RESP_DECERR;
        end
      endcase
    end
    if (r_reg.axi.bvalid && s_axi_bready) begin
      r_next.axi.bvalid = 1'b0;
    end
    r_next.axi.awready = !r_next.axi.aw_got && !r_next.axi.bvalid;
    r_next.axi.wready = !r_next.axi.w_got && !r_next.axi.bvalid;
    if (s_axi_arvalid && r_reg.axi.arready) begin
      r_next.axi.rvalid = 1'b1;
      r_next.axi.rresp = esd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        esd_pkg::REG_CTRL: r_next.axi.rdata = {31'h0, r_reg.ext};
        esd_pkg::REG_STATUS: r_next.axi.rdata = {29'h0, r_reg.st, !r_reg.ins_ready};
        esd_pkg::REG_PTR0: r_next.axi.rdata = {20'h0, r_reg.ptr[0]};
        esd_pkg::REG_PTR1: r_next.axi.rdata = {20'h0, r_reg.ptr[1]};
        esd_pkg::REG_PTR2: r_next.axi.rdata = {20'h0, r_reg.ptr[2]};
        default: begin
          r_next.axi.rdata = 32'h0;
          r_next.axi.rresp = esd_pkg::RESP_DECERR;
        end
      endcase
    end else if (r_reg.axi.rvalid && s_axi_rready) begin
      r_next.axi.rvalid = 1'b0;
    end
    r_next.axi.arready = !r_next.axi.rvalid;

    // ***********************************************
    // extended instruction sequencing
    // ***********************************************
    case (r_reg.st)
      esd_pkg::ESD_IDLE: begin
        if (take && r_reg.ext) begin
          if (ins_word[15:7] == esd_pkg::OP_MOVE_IDX_W1) begin
            r_next.zs = ins_word[6:0];
            r_next.st = esd_pkg::ESD_MV_WORD2;
          end else if (ins_word[15:8] == esd_pkg::OP_PUSH_LIT) begin
            r_next.mem.we = 1'b1;
            r_next.mem.addr = sp;
            r_next.mem.wdata = ins_word[7:0];
            r_next.ptr[esd_pkg::SEL_STACK_PTR] = push_dec;
            r_next.done = 1'b1;
          end else if (ins_word[15:8] == esd_pkg::OP_SUB_PTR) begin
            r_next.ptr[sub_sel] = sub_res;
            if (ins_word[7:6] == esd_pkg::SEL_RETURN) begin
              r_next.pc_load = 1'b1;
              r_next.pc_value = return_stack_top;
              r_next.st = esd_pkg::ESD_RET_NOP;
            end else begin
              r_next.done = 1'b1;
            end
          end else begin
            r_next.done = 1'b1;
          end
        end else if (take) begin
          r_next.done = 1'b1;
        end
      end
      esd_pkg::ESD_MV_WORD2: begin
        if (take) begin
          if (ins_word[15:12] == esd_pkg::OP_MOVE_IDX_W2) begin
            r_next.src = sp + {5'h0, r_reg.zs};
            r_next.dst = idx_sum;
            r_next.src_ind = esd_pkg::is_indirect(sp + {5'h0, r_reg.zs});
            r_next.dst_ind = esd_pkg::is_indirect(idx_sum);
            r_next.mem.re = !esd_pkg::is_indirect(sp + {5'h0, r_reg.zs});
            r_next.mem.addr = sp + {5'h0, r_reg.zs};
            r_next.st = esd_pkg::ESD_MV_READ;
          end else begin
            r_next.done = 1'b1;
            r_next.st = esd_pkg::ESD_IDLE;
          end
        end
      end
      esd_pkg::ESD_MV_READ: begin
        r_next.mem.we = !r_reg.dst_ind;
        r_next.mem.addr = r_reg.dst;
        r_next.mem.wdata = r_reg.src_ind ? 8'h00 : mem_rdata;
        r_next.done = 1'b1;
        r_next.st = esd_pkg::ESD_IDLE;
      end
      esd_pkg::ESD_RET_NOP: begin
        r_next.done = 1'b1;
        r_next.st = esd_pkg::ESD_IDLE;
      end
      default: begin
        r_next.st = esd_pkg::ESD_IDLE;
      end
    endcase
    r_next.ins_ready = (r_next.st == esd_pkg::ESD_IDLE) ||
                       (r_next.st == esd_pkg::ESD_MV_WORD2);

    // ***********************************************
    // standard operand resolution
    // ***********************************************
    r_next.res_valid = std_valid;
    r_next.res_addr = std_addr;
    r_next.res_d = std_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= esd_pkg::ESD_IDLE;
      r_reg.ext <= esd_pkg::CTRL_EXT_RESET;
      r_reg.ins_ready <= 1'b1;
      r_reg.axi.awready <= 1'b1;
      r_reg.axi.wready <= 1'b1;
      r_reg.axi.arready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready = r_reg.axi.awready;
  assign s_axi_wready = r_reg.axi.wready;
  assign s_axi_bvalid = r_reg.axi.bvalid;
  assign s_axi_bresp = r_reg.axi.bresp;
  assign s_axi_arready = r_reg.axi.arready;
  assign s_axi_rvalid = r_reg.axi.rvalid;
  assign s_axi_rdata = r_reg.axi.rdata;
  assign s_axi_rresp = r_reg.axi.rresp;
  assign ins_ready = r_reg.ins_ready;
  assign ins_done = r_reg.done;
  assign pc_load = r_reg.pc_load;
  assign pc_value = r_reg.pc_value;
  assign mem_re = r_reg.mem.re;
  assign mem_we = r_reg.mem.we;
  assign mem_addr = r_reg.mem.addr;
  assign mem_wdata = r_reg.mem.wdata;
  assign res_valid = r_reg.res_valid;
  assign res_addr = r_reg.res_addr;
  assign res_d = r_reg.res_d;

  // ***********************************************
  // assertions
  // ***********************************************
  logic idle_take;
  assign idle_take = take && r_reg.ext && r_reg.st == esd_pkg::ESD_IDLE;

  property p_push;
    @(posedge clk_sys) disable iff (rst)
    idle_take && ins_word[15:8] == esd_pkg::OP_PUSH_LIT |=> mem_we &&
      mem_addr == $past(sp) && mem_wdata == $past(ins_word[7:0]) &&
      sp == $past(sp) - 12'h001;
  endproperty
  a_push: assert property (p_push) else $error("push literal wrong");

  property p_move_seq;
    @(posedge clk_sys) disable iff (rst)
    idle_take && ins_word[15:7] == esd_pkg::OP_MOVE_IDX_W1 ##1
      (take && ins_word[15:12] == esd_pkg::OP_MOVE_IDX_W2) |=> !ins_ready ##1 ins_done;
  endproperty
  a_move_seq: assert property (p_move_seq) else $error("move sequence wrong");

  property p_src_zero;
    @(posedge clk_sys) disable iff (rst)
    r_reg.st == esd_pkg::ESD_MV_READ && r_reg.src_ind && !r_reg.dst_ind |=>
      mem_we && mem_wdata == 8'h00;
  endproperty
  a_src_zero: assert property (p_src_zero) else $error("indirect source not zero");

  property p_dst_nop;
    @(posedge clk_sys) disable iff (rst)
    r_reg.st == esd_pkg::ESD_MV_READ && r_reg.dst_ind |=> !mem_we && ins_done;
  endproperty
  a_dst_nop: assert property (p_dst_nop) else $error("indirect dest written");

  property p_move_copy;
    @(posedge clk_sys) disable iff (rst)
    r_reg.st == esd_pkg::ESD_MV_READ && !r_reg.src_ind && !r_reg.dst_ind |=>
      mem_wdata == $past(mem_rdata) && mem_addr == $past(r_reg.dst);
  endproperty
  a_move_copy: assert property (p_move_copy) else $error("move copy wrong");

  property p_sub;
    @(posedge clk_sys) disable iff (rst)
    idle_take && ins_word[15:8] == esd_pkg::OP_SUB_PTR && ins_word[7:6] != esd_pkg::SEL_RETURN
      |=> r_reg.ptr[$past(ins_word[7:6])] ==
      $past(r_reg.ptr[ins_word[7:6]]) - {6'h00, $past(ins_word[5:0])} && ins_done && ins_ready;
  endproperty
  a_sub: assert property (p_sub) else $error("subtract from pointer wrong");

  property p_ret;
    @(posedge clk_sys) disable iff (rst)
    idle_take && ins_word[15:6] == {esd_pkg::OP_SUB_PTR, esd_pkg::SEL_RETURN} |=>
      pc_load && pc_value == $past(return_stack_top) && !ins_ready ##1 !pc_load && ins_done;
  endproperty
  a_ret: assert property (p_ret) else $error("subtract and return wrong");

  property p_indexed;
    @(posedge clk_sys) disable iff (rst)
    r_reg.ext && !std_a && std_f <= esd_pkg::OFFSET_LIMIT |=>
      res_addr == $past(sp) + {4'h0, $past(std_f)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed operand wrong");

  property p_literal;
    @(posedge clk_sys) disable iff (rst)
    !r_reg.ext && std_a |=> res_addr == {$past(bank_select_register), $past(std_f)} &&
      res_d == $past(std_d);
  endproperty
  a_literal: assert property (p_literal) else $error("banked operand wrong");

  property p_ext_reset;
    @(posedge clk_sys) $past(rst) |-> !r_reg.ext;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("extension on after reset");

  c_push: cover property (@(posedge clk_sys) disable iff (rst)
    idle_take && ins_word[15:8] == esd_pkg::OP_PUSH_LIT);
  c_move: cover property (@(posedge clk_sys) disable iff (rst)
    r_reg.st == esd_pkg::ESD_MV_READ ##1 mem_we);
  c_ret: cover property (@(posedge clk_sys) disable iff (rst) pc_load);
  c_indexed: cover property (@(posedge clk_sys) disable iff (rst)
    r_reg.ext && std_valid && !std_a && std_f <= esd_pkg::OFFSET_LIMIT);
endmodule

// ===== esd_decode_tb_top.sv
`timescale 1ns/10ps
module esd_decode_tb_top;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen, rresp_seen;
  logic ins_valid = 1'h0;
  logic [15:0] ins_word = 16'h0000;
  logic ins_ready, ins_done, pc_load, mem_re, mem_we, res_valid, res_d, pl_seen;
  logic [esd_pkg::PCW-1:0] return_stack_top = 21'h00000, pc_value;
  logic [esd_pkg::AW-1:0] mem_addr, res_addr;
  logic [7:0] mem_wdata, mem_rdata, std_f = 8'h00;
  logic std_valid = 1'h0, std_a = 1'h0, std_d = 1'h0;
  logic [3:0] bank_select_register = 4'h0;
  logic [31:0] rd_data;
  int errors = 0, cmp_count = 0, cyc = 0, wr_count;

  esd_decode dut_u (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ins_valid, .ins_word, .ins_ready,
    .ins_done, .return_stack_top, .pc_load, .pc_value, .mem_re, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .std_valid, .std_f, .std_a, .std_d, .bank_select_register,
    .res_valid, .res_addr, .res_d);
  esd_mem_model model_u (.clk_sys, .mem_re, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .wr_count);

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("BAD timeout expected finish seen hang");
      end_of_test;
    end
  end

  // ****
  // shared tasks
  // ****
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd_data = s_axi_rdata;
    rresp_seen = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(nm, exp, rd_data);
  endtask
  task automatic issue(input logic [15:0] w, input int lat);
    int n;
    @(posedge clk_sys);
    ins_valid <= 1'h1;
    ins_word <= w;
    do @(posedge clk_sys); while (ins_ready !== 1'h1);
    ins_valid <= 1'h0;
    pl_seen = 1'h0;
    n = 0;
    while (lat > 0 && n < 6) begin
      n++;
      @(posedge clk_sys);
      pl_seen = pl_seen | pc_load;
      if (ins_done === 1'h1) break;
    end
    if (lat > 0) chk("done_cycles", lat, n);
  endtask
  task automatic opnd(input logic a, input logic [7:0] f, input logic [11:0] exp);
    @(posedge clk_sys);
    std_valid <= 1'h1;
    std_a <= a;
    std_f <= f;
    std_d <= f[0];
    bank_select_register <= 4'h3;
    @(posedge clk_sys);
    std_valid <= 1'h0;
    @(posedge clk_sys);
    chk("res_addr", exp, res_addr);
    chk("res_valid", 32'h1, res_valid);
    chk("res_d", f[0], res_d);
  endtask

  // ****
  // scenarios
  // ****
  task t_reset;
    rdchk("ctrl", esd_pkg::REG_CTRL, 32'h0);
    rdchk("status", esd_pkg::REG_STATUS, 32'h0);
    for (int i = 0; i < 3; i++) rdchk("ptr", esd_pkg::REG_PTR0 + 8'(4 * i), 32'h0);
    axr(8'h40);
    chk("rresp", esd_pkg::RESP_DECERR, rresp_seen);
    chk("rdata", 32'h0, rd_data);
    axw(8'h40, 32'h1);
    chk("bresp", esd_pkg::RESP_DECERR, bresp_seen);
    axw(esd_pkg::REG_STATUS, 32'hFFFFFFFF);
    chk("bresp", esd_pkg::RESP_OKAY, bresp_seen);
    $display("test reset finished");
  endtask
  task automatic t_ext_off;
    int n;
    axw(esd_pkg::REG_PTR2, 32'h1EC);
    n = wr_count;
    issue({esd_pkg::OP_PUSH_LIT, 8'h08}, 1);
    rdchk("sp", esd_pkg::REG_PTR2, 32'h1EC);
    chk("writes", n, wr_count);
    opnd(1'h0, 8'h10, 12'h010);
    opnd(1'h0, 8'h60, 12'hF60);
    opnd(1'h1, 8'h10, 12'h310);
    $display("test extension off finished");
  endtask
  task t_push;
    axw(esd_pkg::REG_CTRL, 32'h1);
    rdchk("ctrl", esd_pkg::REG_CTRL, 32'h1);
    issue({esd_pkg::OP_PUSH_LIT, 8'h08}, 1);
    rdchk("sp", esd_pkg::REG_PTR2, 32'h1EB);
    chk("mem", 32'h08, model_u.mem[12'h1EC]);
    axw(esd_pkg::REG_PTR2, 32'h0);
    issue({esd_pkg::OP_PUSH_LIT, 8'hA5}, 1);
    rdchk("sp", esd_pkg::REG_PTR2, 32'hFFF);
    chk("mem", 32'hA5, model_u.mem[12'h000]);
    $display("test push finished");
  endtask
  task t_sub;
    for (int i = 0; i < 3; i++) begin
      axw(esd_pkg::REG_PTR0 + 8'(4 * i), 32'h3FF);
      issue({esd_pkg::OP_SUB_PTR, 2'(i), 6'h23}, 1);
      rdchk("ptr", esd_pkg::REG_PTR0 + 8'(4 * i), 32'h3DC);
    end
    axw(esd_pkg::REG_PTR0, 32'h20);
    issue({esd_pkg::OP_SUB_PTR, 2'h0, 6'h3F}, 1);
    rdchk("ptr", esd_pkg::REG_PTR0, 32'hFE1);
    $display("test subtract finished");
  endtask
  task t_ret;
    axw(esd_pkg::REG_PTR2, 32'h3FF);
    return_stack_top <= 21'h1ABCD;
    issue({esd_pkg::OP_SUB_PTR, esd_pkg::SEL_RETURN, 6'h23}, 2);
    chk("pc_load", 32'h1, pl_seen);
    chk("pc_value", 32'h1ABCD, pc_value);
    rdchk("sp", esd_pkg::REG_PTR2, 32'h3DC);
    rdchk("ptr", esd_pkg::REG_PTR0, 32'hFE1);
    $display("test subtract and return finished");
  endtask
  task automatic t_move;
    logic [11:0] sp [4] = '{12'h080, 12'hFF0, 12'hFE0, 12'hFE0};
    logic [6:0] zs [4] = '{7'h05, 7'h7F, 7'h0B, 7'h00};
    logic [6:0] zd [4] = '{7'h06, 7'h10, 7'h00, 7'h0F};
    logic [7:0] sv [4] = '{8'h33, 8'h5A, 8'h77, 8'h44};
    logic [7:0] ev [4] = '{8'h33, 8'h5A, 8'h00, 8'h99};
    int wc [4] = '{1, 1, 1, 0};
    logic [11:0] s, d;
    int n;
    for (int i = 0; i < 4; i++) begin
      axw(esd_pkg::REG_PTR2, {20'h0, sp[i]});
      s = sp[i] + {5'h00, zs[i]};
      d = sp[i] + {5'h00, zd[i]};
      model_u.mem[s] = sv[i];
      model_u.mem[d] = 8'h99;
      n = wr_count;
      issue({esd_pkg::OP_MOVE_IDX_W1, zs[i]}, 0);
      issue({esd_pkg::OP_MOVE_IDX_W2, 5'h15, zd[i]}, 2);
      rdchk("sp", esd_pkg::REG_PTR2, {20'h0, sp[i]});
      chk("dst", ev[i], model_u.mem[d]);
      chk("writes", n + wc[i], wr_count);
    end
    $display("test move finished");
  endtask
  task t_opnd;
    axw(esd_pkg::REG_PTR2, 32'hA00);
    opnd(1'h0, 8'h10, 12'hA10);
    opnd(1'h0, 8'h5F, 12'hA5F);
    opnd(1'h0, 8'h60, 12'hF60);
    opnd(1'h1, 8'h10, 12'h310);
    axw(esd_pkg::REG_PTR2, 32'hFF0);
    opnd(1'h0, 8'h5F, 12'h04F);
    axw(esd_pkg::REG_PTR2, 32'h0);
    opnd(1'h0, 8'h10, 12'h010);
    $display("test operand finished");
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset;
    t_ext_off;
    t_push;
    t_sub;
    t_ret;
    t_move;
    t_opnd;
    end_of_test;
  end
endmodule

// ===== esd_mem_model.sv
`timescale 1ns/10ps
// ****
// data memory behind the decoder, read data stands while mem_re stands
// ****
module esd_mem_model (
  input wire logic clk_sys,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [esd_pkg::AW-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output int wr_count
);
  logic [7:0] mem [4096];
  initial begin
    wr_count = 0;
  end
  // decoder samples read data at the edge that ends its mem_re cycle;
  // without a read the lines show the inverse so a stray sample shows up
  assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule

// ===== esd_pkg.sv
package esd_pkg;

  // ***********************************************
  // widths and opcode fields
  // ***********************************************
  localparam int AW = 12;
  localparam int PCW = 21;
  localparam logic [8:0] OP_MOVE_IDX_W1 = 9'h1D7;
  localparam logic [3:0] OP_MOVE_IDX_W2 = 4'hF;
  localparam logic [7:0] OP_PUSH_LIT = 8'hFA;
  localparam logic [7:0] OP_SUB_PTR = 8'hE9;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_STACK_PTR = 2'h2;
  localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [7:0] PUSH_STEP = 8'h01;

  // ***********************************************
  // indirect-addressing register groups
  // ***********************************************
  localparam logic [11:0] IND_TOP0 = 12'hFEF;
  localparam logic [11:0] IND_TOP1 = 12'hFE7;
  localparam logic [11:0] IND_TOP2 = 12'hFDF;
  localparam logic [11:0] IND_SPAN = 12'h005;

  // ***********************************************
  // register map and bus answers
  // ***********************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PTR0 = 8'h08;
  localparam logic [7:0] REG_PTR1 = 8'h0C;
  localparam logic [7:0] REG_PTR2 = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic CTRL_EXT_RESET = 1'b0;

  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [1:0] {
    ESD_IDLE = 2'h0,
    ESD_MV_WORD2 = 2'h1,
    ESD_MV_READ = 2'h3,
    ESD_RET_NOP = 2'h2
  } esd_state_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
  } esd_mem_req_t;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } esd_axi_t;

  typedef struct packed {
    esd_state_t st;
    logic ext;
    logic [2:0][AW-1:0] ptr;
    logic [AW-1:0] src;
    logic [AW-1:0] dst;
    logic [6:0] zs;
    logic src_ind;
    logic dst_ind;
    logic ins_ready;
    logic done;
    esd_mem_req_t mem;
    logic pc_load;
    logic [PCW-1:0] pc_value;
    logic res_valid;
    logic [AW-1:0] res_addr;
    logic res_d;
    esd_axi_t axi;
  } esd_regs_t;

  function automatic logic is_indirect(input logic [AW-1:0] a);
    is_indirect = (a <= IND_TOP0 && a > IND_TOP0 - IND_SPAN) ||
                  (a <= IND_TOP1 && a > IND_TOP1 - IND_SPAN) ||
                  (a <= IND_TOP2 && a > IND_TOP2 - IND_SPAN);
  endfunction

endpackage

// ===== esd_ptr_alu.sv
`timescale 1ns/10ps
// ***********************************************
// pointer plus or minus literal, wraps in data space
// ***********************************************
module esd_ptr_alu (
  input wire logic [esd_pkg::AW-1:0] base,
  input wire logic [7:0] off,
  input wire logic sub,
  output logic [esd_pkg::AW-1:0] result
);
  always_comb begin
    if (sub) begin
      result = base - {4'h0, off};
    end else begin
      result = base + {4'h0, off};
    end
  end
endmodule
